// ---- design/pms_supervisor.sv ----
// Purpose: frame timing, beacon watch and arq limits of a plc mac
// Assumes: all event inputs are one-cycle pulses from logic on clk
// Notes: seconds timebase is divided from clk, shortenable by param
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module pms_supervisor
    import pms_pkg::*;
#(
    parameter int SEC_CNT = SEC_CYCLES // cycles per second
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic symTick,
    input wire logic beaconExpected,
    input wire logic beaconRx,
    input wire logic prnRx,
    input wire logic [3:0] txReq,
    input wire logic txAttempt,
    input wire logic ackRx,
    input wire logic congInd,
    input wire logic ackQueued,
    input wire logic ackSent,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic frameStart,
    output logic beaconSlot,
    output logic scpActive,
    output logic [3:0] txGrant,
    output logic prnRespond,
    output logic switchUnavail,
    output logic arqReady,
    output logic retxReq,
    output logic retxFail,
    output logic congWait,
    output logic connDead,
    output logic ackForce,
    output logic randSeqDue
);
    // highest set request wins, returned one-hot
    function automatic logic [3:0] hiPrio(input logic [3:0] req);
        logic [3:0] g;
        g = 4'h0;
        for (int i = 0; i < PRIO_LEVELS; i++) begin
            if (req[i]) begin
                g = 4'h0;
                g[i] = 1'b1;
            end
        end
        return g;
    endfunction

    // seconds prescaler
    logic [31:0] preCnt_r, preCnt_nxt;
    logic secTick_r, secTick_nxt;
    always_comb begin
        secTick_nxt = 1'b0;
        preCnt_nxt = preCnt_r + 32'h0000_0001;
        if (preCnt_r >= 32'(SEC_CNT - 1)) begin
            preCnt_nxt = 32'h0000_0000;
            secTick_nxt = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            preCnt_r <= 32'h0000_0000;
            secTick_r <= 1'b0;
        end else begin
            preCnt_r <= preCnt_nxt;
            secTick_r <= secTick_nxt;
        end
    end

    // software registers
    logic baseMode_r, baseMode_nxt; // node acts as base
    logic [8:0] scpLen_r, scpLen_nxt; // contention length, symbols
    logic [5:0] cfpAlloc_r, cfpAlloc_nxt; // cfp count per frame
    logic cfgErr_r, cfgErr_nxt; // sticky rejected write
    logic clrFail, seqSent; // command pulses
    always_comb begin
        baseMode_nxt = baseMode_r;
        scpLen_nxt = scpLen_r;
        cfpAlloc_nxt = cfpAlloc_r;
        cfgErr_nxt = cfgErr_r;
        clrFail = 1'b0;
        seqSent = 1'b0;
        if (regWr && regAddr == ADDR_CMD) begin
            clrFail = regWdata[CMD_CLR_FAIL];
            seqSent = regWdata[CMD_SEQ_SENT];
            if (regWdata[CMD_CLR_CFGERR]) begin
                cfgErr_nxt = 1'b0;
            end
        end
        if (regWr) begin
            case (regAddr)
                ADDR_CTRL: baseMode_nxt = regWdata[0];
                ADDR_SCP: begin
                    // short or oversize length keeps the old one
                    if (regWdata[8:0] >= SCP_MIN &&
                        regWdata[8:0] <= SCP_MAX &&
                        regWdata[31:9] == 23'h000000) begin
                        scpLen_nxt = regWdata[8:0];
                    end else begin
                        cfgErr_nxt = 1'b1;
                    end
                end
                ADDR_CFP: begin
                    if (regWdata[5:0] <= CFP_MAX &&
                        regWdata[31:6] == 26'h0000000) begin
                        cfpAlloc_nxt = regWdata[5:0];
                    end else begin
                        cfgErr_nxt = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            baseMode_r <= 1'b0;
            scpLen_r <= SCP_MIN;
            cfpAlloc_r <= 6'h00;
            cfgErr_r <= 1'b0;
        end else begin
            baseMode_r <= baseMode_nxt;
            scpLen_r <= scpLen_nxt;
            cfpAlloc_r <= cfpAlloc_nxt;
            cfgErr_r <= cfgErr_nxt;
        end
    end

    // frame symbol counter and windows
    logic [8:0] symCnt_r, symCnt_nxt;
    logic frameStart_r, frameStart_nxt;
    logic beaconSlot_r, beaconSlot_nxt;
    logic scpActive_r, scpActive_nxt;
    logic [3:0] txGrant_r, txGrant_nxt;
    always_comb begin
        symCnt_nxt = symCnt_r;
        frameStart_nxt = 1'b0;
        if (symTick) begin
            if (symCnt_r == FRAME_LEN - 9'h001) begin
                symCnt_nxt = 9'h000;
                frameStart_nxt = 1'b1;
            end else begin
                symCnt_nxt = symCnt_r + 9'h001;
            end
        end
        // beacon slot sized from the fixed beacon length
        beaconSlot_nxt = symCnt_nxt < BEACON_LEN;
        scpActive_nxt = !beaconSlot_nxt &&
                        symCnt_nxt < BEACON_LEN + scpLen_r;
        txGrant_nxt = hiPrio(txReq);
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            symCnt_r <= 9'h000;
            frameStart_r <= 1'b0;
            beaconSlot_r <= 1'b1;
            scpActive_r <= 1'b0;
            txGrant_r <= 4'h0;
        end else begin
            symCnt_r <= symCnt_nxt;
            frameStart_r <= frameStart_nxt;
            beaconSlot_r <= beaconSlot_nxt;
            scpActive_r <= scpActive_nxt;
            txGrant_r <= txGrant_nxt;
        end
    end

    // missed beacon and promotion-needed counters
    logic [2:0] missCnt_r, missCnt_nxt;
    logic [1:0] prnCnt_r, prnCnt_nxt;
    logic unavail_r, unavail_nxt;
    logic prnResp_r, prnResp_nxt;
    always_comb begin
        missCnt_nxt = missCnt_r;
        prnCnt_nxt = prnCnt_r;
        prnResp_nxt = 1'b0;
        // a beacon seen at any time counts as received, the slot is not checked
        if (beaconRx) begin
            missCnt_nxt = 3'h0;
        end else if (beaconExpected && missCnt_r < MISS_LIMIT) begin
            missCnt_nxt = missCnt_r + 3'h1;
        end
        unavail_nxt = missCnt_nxt == MISS_LIMIT;
        if (prnRx) begin
            if (prnCnt_r == PRN_IGNORE) begin
                prnResp_nxt = 1'b1;
                prnCnt_nxt = 2'h0;
            end else begin
                prnCnt_nxt = prnCnt_r + 2'h1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            missCnt_r <= 3'h0;
            prnCnt_r <= 2'h0;
            unavail_r <= 1'b0;
            prnResp_r <= 1'b0;
        end else begin
            missCnt_r <= missCnt_nxt;
            prnCnt_r <= prnCnt_nxt;
            unavail_r <= unavail_nxt;
            prnResp_r <= prnResp_nxt;
        end
    end

    // retransmission and congestion state
    pms_arq_t state_r, state_nxt;
    logic [2:0] txCnt_r, txCnt_nxt;
    logic [2:0] congCnt_r, congCnt_nxt;
    logic retxReq_r, retxReq_nxt;
    logic retxFail_r, retxFail_nxt;
    logic connDead_r, connDead_nxt;
    logic arqReady_r, arqReady_nxt;
    logic arqStart, arqStop, arqBusy, arqDone;
    logic [14:0] arqLoad;
    always_comb begin
        state_nxt = state_r;
        txCnt_nxt = txCnt_r;
        congCnt_nxt = congCnt_r;
        retxReq_nxt = 1'b0;
        retxFail_nxt = retxFail_r;
        connDead_nxt = connDead_r;
        arqStart = 1'b0;
        arqStop = 1'b0;
        // ack wait covers the peer's hold limit plus two ticks
        arqLoad = ACK_HOLD_SEC + SEC_ONE + SEC_ONE;
        case (state_r)
            ARQ_IDLE: begin
                if (txAttempt && txCnt_r < TX_LIMIT) begin
                    txCnt_nxt = txCnt_r + 3'h1;
                    arqStart = 1'b1;
                    state_nxt = ARQ_WAIT;
                end
            end
            ARQ_WAIT: begin
                if (ackRx) begin
                    txCnt_nxt = 3'h0;
                    congCnt_nxt = 3'h0;
                    arqStop = 1'b1;
                    state_nxt = ARQ_IDLE;
                end else if (congInd) begin
                    // a congested attempt is not spent against the
                    // attempt limit, else the streak could never reach 7
                    txCnt_nxt = txCnt_r - 3'h1;
                    congCnt_nxt = congCnt_r + 3'h1;
                    if (congCnt_nxt == CONG_LIMIT) begin
                        connDead_nxt = 1'b1;
                        arqStop = 1'b1;
                        state_nxt = ARQ_FAIL;
                    end else begin
                        // extra tick so the wait is never short
                        arqLoad = CONG_BACKOFF_SEC + SEC_ONE;
                        arqStart = 1'b1;
                        state_nxt = ARQ_BACKOFF;
                    end
                end else if (arqDone) begin
                    congCnt_nxt = 3'h0; // streak broken
                    if (txCnt_r == TX_LIMIT) begin
                        retxFail_nxt = 1'b1;
                        state_nxt = ARQ_FAIL;
                    end else begin
                        retxReq_nxt = 1'b1;
                        state_nxt = ARQ_IDLE;
                    end
                end
            end
            ARQ_BACKOFF: begin
                if (ackRx) begin
                    txCnt_nxt = 3'h0;
                    congCnt_nxt = 3'h0;
                    arqStop = 1'b1;
                    state_nxt = ARQ_IDLE;
                end else if (arqDone) begin
                    // back-off over: attempt count never at the limit here
                    retxReq_nxt = 1'b1;
                    state_nxt = ARQ_IDLE;
                end
            end
            ARQ_FAIL: begin
                // only software brings a dead link back
                if (clrFail) begin
                    txCnt_nxt = 3'h0;
                    congCnt_nxt = 3'h0;
                    retxFail_nxt = 1'b0;
                    connDead_nxt = 1'b0;
                    state_nxt = ARQ_IDLE;
                end
            end
            default: state_nxt = ARQ_IDLE;
        endcase
        arqReady_nxt = state_nxt == ARQ_IDLE && txCnt_nxt < TX_LIMIT;
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= ARQ_IDLE;
            txCnt_r <= 3'h0;
            congCnt_r <= 3'h0;
            retxReq_r <= 1'b0;
            retxFail_r <= 1'b0;
            connDead_r <= 1'b0;
            arqReady_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            txCnt_r <= txCnt_nxt;
            congCnt_r <= congCnt_nxt;
            retxReq_r <= retxReq_nxt;
            retxFail_r <= retxFail_nxt;
            connDead_r <= connDead_nxt;
            arqReady_r <= arqReady_nxt;
        end
    end

    // ack wait or congestion back-off timer
    pms_sec_timer u_arqTmr (
        .clk(clk), .nrst(nrst), .start(arqStart), .stop(arqStop),
        .secTick(secTick_r), .loadVal(arqLoad),
        .busy(arqBusy), .done(arqDone)
    );

    // receiver side: a held ack is forced out at the limit
    logic holdStart, holdBusy, holdDone;
    assign holdStart = ackQueued && !holdBusy;
    pms_sec_timer u_holdTmr (
        .clk(clk), .nrst(nrst), .start(holdStart), .stop(ackSent),
        .secTick(secTick_r), .loadVal(ACK_HOLD_SEC),
        .busy(holdBusy), .done(holdDone)
    );

    // base node random sequence renewal reminder
    logic seqDue_r, seqDue_nxt;
    logic seqStart, seqBusy, seqDone;
    assign seqStart = baseMode_r && !seqBusy && !seqDue_r;
    pms_sec_timer u_seqTmr (
        .clk(clk), .nrst(nrst), .start(seqStart),
        .stop(seqSent || !baseMode_r),
        .secTick(secTick_r), .loadVal(RAND_SEQ_SEC),
        .busy(seqBusy), .done(seqDone)
    );
    // expiry beats a clear in the same cycle
    always_comb begin
        seqDue_nxt = seqDue_r;
        if (seqSent || !baseMode_r) begin
            seqDue_nxt = 1'b0;
        end
        if (seqDone) begin
            seqDue_nxt = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            seqDue_r <= 1'b0;
        end else begin
            seqDue_r <= seqDue_nxt;
        end
    end

    // read mux, data valid only in the cycle after the strobe
    logic [31:0] rdata_r, rdata_nxt;
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (regRd) begin
            case (regAddr)
                ADDR_CTRL: rdata_nxt[0] = baseMode_r;
                ADDR_SCP: rdata_nxt[8:0] = scpLen_r;
                ADDR_CFP: rdata_nxt[5:0] = cfpAlloc_r;
                ADDR_STATUS: rdata_nxt = {16'h0000, congCnt_r,
                    txCnt_r, prnCnt_r, missCnt_r, cfgErr_r,
                    seqDue_r, connDead_r, retxFail_r, unavail_r};
                // switching and priority fixed, multicast on base
                ADDR_CAPS: rdata_nxt[2:0] = {baseMode_r, 2'h3};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign regRdata = rdata_r;
    assign frameStart = frameStart_r;
    assign beaconSlot = beaconSlot_r;
    assign scpActive = scpActive_r;
    assign txGrant = txGrant_r;
    assign prnRespond = prnResp_r;
    assign switchUnavail = unavail_r;
    assign arqReady = arqReady_r;
    assign retxReq = retxReq_r;
    assign retxFail = retxFail_r;
    assign congWait = state_r == ARQ_BACKOFF;
    assign connDead = connDead_r;
    assign ackForce = holdDone;
    assign randSeqDue = seqDue_r;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence congEnter_s;
        state_r == ARQ_WAIT && congInd && !ackRx &&
        congCnt_r < CONG_LIMIT - 3'h1;
    endsequence
    sequence backoffHold_s;
        congWait && !retxReq ##1 congWait && !retxReq;
    endsequence
    frame_wrap_a: assert property (symTick &&
        symCnt_r == FRAME_LEN - 9'h001 |=> frameStart && symCnt_r == 0)
        else $error("frame did not wrap at its length");
    beacon_len_a: assert property (
        beaconSlot == (symCnt_r < BEACON_LEN))
        else $error("beacon slot length wrong");
    scp_min_a: assert property (scpLen_r >= SCP_MIN)
        else $error("contention period too short");
    cfp_max_a: assert property (cfpAlloc_r <= CFP_MAX)
        else $error("too many contention-free periods");
    prio_top_a: assert property (txReq[3] |=> txGrant == 4'h8)
        else $error("top priority not granted");
    prn_answer_a: assert property (
        prnRx && prnCnt_r == PRN_IGNORE |=> prnRespond)
        else $error("fourth promotion-needed ignored");
    miss_beacon_a: assert property (beaconExpected &&
        !beaconRx && missCnt_r == MISS_LIMIT - 3'h1 |=> switchUnavail)
        else $error("switch not declared unavailable");
    tx_fail_a: assert property (state_r == ARQ_WAIT && arqDone &&
        !ackRx && !congInd && txCnt_r == TX_LIMIT |=> retxFail)
        else $error("no failure after last attempt");
    backoff_hold_a: assert property (congEnter_s |=> backoffHold_s)
        else $error("congestion back-off not held");
    conn_dead_a: assert property (state_r == ARQ_WAIT &&
        congInd && !ackRx && congCnt_r == CONG_LIMIT - 3'h1 |=> connDead)
        else $error("connection not declared dead");
    ack_clear_a: assert property (state_r == ARQ_WAIT &&
        ackRx |=> txCnt_r == 3'h0 && congCnt_r == 3'h0)
        else $error("ack did not clear counters");
    caps_read_a: assert property (
        regRd && regAddr == ADDR_CAPS |=> regRdata[1:0] == 2'h3)
        else $error("capability flags wrong");
endmodule

// ---- design/pms_pkg.sv ----
// Purpose: shared constants for the medium access timing supervisor
// Assumes: 50 MHz clk, symbol tick from the modem on the same clock
// Notes: register map and timing figures live here only
package pms_pkg;
    // clock and seconds timebase
    localparam int CLK_PERIOD_NS = 20;
    localparam int SEC_NS = 1000000000;
    localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
    // frame timing in symbols
    localparam logic [8:0] FRAME_LEN = 9'h114;
    localparam logic [8:0] BEACON_LEN = 9'h004;
    localparam logic [8:0] SCP_MIN = 9'h040;
    localparam logic [8:0] SCP_MAX = FRAME_LEN - BEACON_LEN;
    localparam logic [5:0] CFP_MAX = 6'h20;
    localparam int PRIO_LEVELS = 4;
    // event limits
    localparam logic [1:0] PRN_IGNORE = 2'h3;
    localparam logic [2:0] MISS_LIMIT = 3'h5;
    localparam logic [2:0] TX_LIMIT = 3'h5;
    localparam logic [2:0] CONG_LIMIT = 3'h7;
    // long times in seconds
    localparam logic [14:0] CONG_BACKOFF_SEC = 15'h0002;
    localparam logic [14:0] ACK_HOLD_SEC = 15'h0007;
    localparam logic [14:0] RAND_SEQ_SEC = 15'h7FFF;
    localparam logic [14:0] SEC_ONE = 15'h0001;
    // register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SCP = 8'h04;
    localparam logic [7:0] ADDR_CFP = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_CAPS = 8'h10;
    localparam logic [7:0] ADDR_CMD = 8'h14;
    // command bits
    localparam int CMD_CLR_FAIL = 0;
    localparam int CMD_SEQ_SENT = 1;
    localparam int CMD_CLR_CFGERR = 2;
    // arq states, one-hot
    typedef enum logic [3:0] {
        ARQ_IDLE = 4'h1,
        ARQ_WAIT = 4'h2,
        ARQ_BACKOFF = 4'h4,
        ARQ_FAIL = 4'h8
    } pms_arq_t;
endpackage

// ---- design/pms_sec_timer.sv ----
// Purpose: countdown timer in whole seconds
// Assumes: secTick is a one-cycle pulse once per second
// Notes: done fires on the loadVal-th tick after start
`timescale 1ns/1ps
module pms_sec_timer
    import pms_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic stop,
    input wire logic secTick,
    input wire logic [14:0] loadVal,
    output logic busy,
    output logic done
);
    logic [14:0] cnt_r, cnt_nxt; // seconds left
    logic busy_r, busy_nxt; // running
    logic done_r, done_nxt; // expiry pulse

    // next state: stop beats start, start restarts a running timer
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (stop) begin
            busy_nxt = 1'b0;
        end else if (start) begin
            cnt_nxt = loadVal;
            busy_nxt = 1'b1;
        end else if (busy_r && secTick) begin
            if (cnt_r <= SEC_ONE) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - SEC_ONE;
            end
        end
    end

    // registers only
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_r <= 15'h0000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = busy_r;
    assign done = done_r;
endmodule

// ---- verif/pms_peer.sv ----
// Purpose: peer node answering each data packet
// Assumes: mode 0 silent, 1 acknowledge, 2 congestion
// Notes: DLY gives a prompt or a slow answer
`timescale 1ns/1ps
module pms_peer #(
    parameter int DLY = 3 // answer delay in cycles
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic txAttempt,
    input wire logic [1:0] mode,
    output logic ackRx,
    output logic congInd
);
    logic [9:0] cnt; // cycles to answer, zero when idle
    // a held answer stands for a receiver batching acks
    always_ff @(posedge clk) begin
        ackRx <= cnt == 10'h001 && mode == 2'h1;
        congInd <= cnt == 10'h001 && mode == 2'h2;
        if (!nrst)
            cnt <= 10'h000;
        else if (cnt != 10'h000)
            cnt <= cnt - 10'h001;
        else if (txAttempt && mode != 2'h0)
            cnt <= 10'(DLY);
    end
endmodule

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for the timing supervisor
// Assumes: one second shortened to SC cycles
// Notes: event inputs travel in one pulse vector
`timescale 1ns/1ps
module testbench;
    import pms_pkg::*;
    localparam int SC = 10; // cycles per second
    logic clk = 1'b0, nrst = 1'b0, symTick = 1'b0;
    logic [5:0] ev = 6'h00; // event pulses, bit 0 prnRx
    logic [3:0] txReq = 4'h0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0, regRd = 1'b0;
    logic [1:0] mode = 2'h0; // peer answer kind
    logic ackRx, congInd, frameStart, beaconSlot, scpActive, prnRespond;
    logic switchUnavail, arqReady, retxReq, retxFail, congWait, connDead;
    logic ackForce, randSeqDue;
    logic [3:0] txGrant;
    logic [31:0] regRdata, d;
    int numErrors = 0, samplesChecked = 0;
    wire [4:0] obs = {connDead, ackForce, congWait, retxReq | retxFail,
        arqReady}; // flags a wait can watch
    pms_supervisor #(.SEC_CNT(SC)) i_dut (.clk, .nrst, .symTick, .txReq,
        .beaconExpected(ev[1]), .beaconRx(ev[2]), .prnRx(ev[0]), .ackRx,
        .txAttempt(ev[3]), .congInd, .ackQueued(ev[4]), .ackSent(ev[5]),
        .regAddr, .regWdata, .regWr, .regRd, .regRdata, .frameStart,
        .beaconSlot, .scpActive, .txGrant, .prnRespond, .switchUnavail,
        .arqReady, .retxReq, .retxFail, .congWait, .connDead, .ackForce,
        .randSeqDue);
    pms_peer i_peer (.clk, .nrst, .txAttempt(ev[3]), .mode, .ackRx,
        .congInd);
    always #10 clk = ~clk;
    task automatic finishTest();
        $display("errors %0d of %0d", numErrors, samplesChecked);
        if (numErrors == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        samplesChecked++;
        if (s !== e) begin
            numErrors++;
            $display("[ERR] %s exp %0h seen %0h", n, e, s);
        end
    endtask
    // one bus cycle; read data lands in the following cycle
    task automatic acc(logic w, logic [7:0] a, logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= w;
        regRd <= !w;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic pulse(logic [5:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 6'h00;
        #1;
    endtask
    task automatic waitObs(int b, int lim, output int n);
        for (n = 0; obs[b] !== 1'b1 && n < lim; n++) begin
            @(posedge clk);
            #1;
        end
        if (obs[b] !== 1'b1) begin
            chk("wait", b, 32'hFF);
            finishTest();
        end
    endtask
    task automatic tFrame();
        for (int k = 1; k <= 280; k++) begin
            @(posedge clk);
            symTick <= 1'b1;
            @(posedge clk);
            symTick <= 1'b0;
            #1 chk("frame", frameStart, 32'(k == 276));
            chk("beacon", beaconSlot, 32'(k % 276 < 4));
            chk("scp", scpActive, 32'(k % 276 inside {[4:67]}));
        end
        $display("frame test done");
    endtask
    task automatic tReg();
        acc(1'b0, ADDR_CAPS, 32'h0);
        chk("caps", d, 32'h00000003);
        acc(1'b1, ADDR_SCP, 32'h0000003F);
        acc(1'b0, ADDR_SCP, 32'h0);
        chk("scpLen", d, 32'h00000040);
        acc(1'b0, ADDR_STATUS, 32'h0);
        chk("cfgErr", d[4], 32'h1);
        acc(1'b1, ADDR_CMD, 32'(1 << CMD_CLR_CFGERR));
        acc(1'b0, ADDR_STATUS, 32'h0);
        chk("cfgClr", d[4], 32'h0);
        acc(1'b1, ADDR_SCP, 32'h00000110);
        acc(1'b0, ADDR_SCP, 32'h0);
        chk("scpMax", d, 32'h00000110);
        acc(1'b1, ADDR_SCP, 32'h00000040);
        acc(1'b1, ADDR_CFP, 32'h00000021);
        acc(1'b0, ADDR_CFP, 32'h0);
        chk("cfpOver", d, 32'h0);
        acc(1'b1, ADDR_CFP, 32'h00000020);
        acc(1'b0, ADDR_CFP, 32'h0);
        chk("cfpLen", d, 32'h00000020);
        acc(1'b1, ADDR_CTRL, 32'h00000001);
        acc(1'b0, ADDR_CAPS, 32'h0);
        chk("capsBase", d, 32'h00000007);
        chk("seqDue", randSeqDue, 32'h0);
        acc(1'b1, ADDR_CTRL, 32'h0);
        acc(1'b0, 8'h40, 32'h0);
        chk("unmapped", d, 32'h0);
        $display("register test done");
    endtask
    task automatic tEvt();
        for (int k = 1; k <= 10; k++) begin
            pulse(k == 5 ? 6'h05 : 6'h03);
            chk("prn", prnRespond, 32'(k % 4 == 0));
            chk("unavail", switchUnavail, 32'(k == 10));
        end
        pulse(6'h04);
        chk("unavailClr", switchUnavail, 32'h0);
        $display("event test done");
    endtask
    task automatic tArq();
        int c;
        for (int k = 1; k <= 5; k++) begin
            waitObs(0, 20 * SC, c);
            pulse(6'h08);
            waitObs(1, 12 * SC, c);
            chk("ackWait", 32'(c >= 7 * SC), 32'h1);
            chk("retxFail", retxFail, 32'(k == 5));
        end
        acc(1'b1, ADDR_CMD, 32'(1 << CMD_CLR_FAIL));
        chk("failClr", retxFail, 32'h0);
        $display("arq test done");
    endtask
    task automatic tCong();
        int c;
        mode <= 2'h2;
        for (int k = 1; k <= 7; k++) begin
            waitObs(0, 20 * SC, c);
            pulse(6'h08);
            waitObs(k == 7 ? 4 : 2, 2 * SC, c);
            chk("dead", connDead, 32'(k == 7));
            if (k < 7) begin
                waitObs(1, 5 * SC, c);
                chk("backoff", 32'(c > 2 * SC - 4), 32'h1);
            end
        end
        $display("congestion test done");
    endtask
    task automatic tPrio();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            txReq <= 4'(4'h1 << k) | 4'h1;
            @(posedge clk);
            #1 chk("grant", txGrant, 32'(4'h1 << k));
        end
        @(posedge clk);
        txReq <= 4'h0;
        @(posedge clk);
        #1 chk("grantIdle", txGrant, 32'h0);
        $display("priority test done");
    endtask
    task automatic tAck();
        int c;
        acc(1'b1, ADDR_CMD, 32'(1 << CMD_CLR_FAIL));
        pulse(6'h08);
        waitObs(1, 5 * SC, c);
        acc(1'b0, ADDR_STATUS, 32'h0);
        chk("deadClr", d[2], 32'h0);
        chk("congCnt", d[15:13], 32'h1);
        mode <= 2'h1;
        pulse(6'h08);
        waitObs(0, 2 * SC, c);
        acc(1'b0, ADDR_STATUS, 32'h0);
        chk("ackClr", d[15:10], 32'h0);
        $display("ack test done");
    endtask
    task automatic tHold();
        int c;
        int n = 0;
        pulse(6'h10);
        waitObs(3, 8 * SC, c);
        chk("holdMin", 32'(c >= 6 * SC - 2), 32'h1);
        chk("holdMax", 32'(c <= 7 * SC + 2), 32'h1);
        pulse(6'h10);
        pulse(6'h20);
        repeat (8 * SC) begin
            @(posedge clk);
            #1 n += int'(ackForce === 1'b1);
        end
        chk("ackStop", n, 32'h0);
        $display("ack hold test done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        tFrame();
        tReg();
        tPrio();
        tEvt();
        tArq();
        tCong();
        tAck();
        tHold();
        finishTest();
    end
endmodule
